/* File: amp_int_cfg.svh */
`ifndef AMP_INT_CFG_SVH
`define AMP_INT_CFG_SVH

// register offsets on page 0 of the control port
`define MASK_LB_OFS 8'h1b
`define MASK_CS_OFS 8'h1c
`define MASK_PC_OFS 8'h1d
`define LIVE_LB_OFS 8'h20
`define LIVE_CS_OFS 8'h21
`define LIVE_PC_OFS 8'h22

// reset values of the three mask registers
`define MASK_LB_RESET 8'ha6
`define MASK_CS_RESET 8'hdf
`define MASK_PC_RESET 8'hff

// bits that carry a real source; the rest are reserved
`define USED_LB 8'h3f
`define USED_CS 8'hff
`define USED_PC 8'h98

// field positions in the load and brownout register
`define LB_DIAG_BIT 5
`define LB_SPK_MSB 4
`define LB_SPK_LSB 3
`define LB_BO_START_BIT 2
`define LB_BO_ACTIVE_BIT 1
`define LB_BATT_BO_BIT 0

// field positions in the power and clock register
`define PC_DOWN_BIT 7
`define PC_MIC_BIT 4
`define PC_SERIAL_BIT 3

// read answer for an unmapped offset
`define RDATA_NONE 8'h00

`endif

/* File: amp_int_pkg.sv */
package amp_int_pkg;

   // one control-port register
   typedef logic [7:0] reg_byte_t;

   // speaker load masking field
   typedef enum logic [1:0] {
      SPK_MASK_NONE  = 2'b00,
      SPK_MASK_OPEN  = 2'b01,
      SPK_MASK_SHORT = 2'b10,
      SPK_MASK_BOTH  = 2'b11
   } spk_mask_t;

   // register selected by the decoded offset
   typedef enum logic [2:0] {
      SEL_NONE    = 3'b000,
      SEL_MASK_LB = 3'b001,
      SEL_MASK_CS = 3'b010,
      SEL_MASK_PC = 3'b011,
      SEL_LIVE_LB = 3'b100,
      SEL_LIVE_CS = 3'b101,
      SEL_LIVE_PC = 3'b110
   } reg_sel_t;

endpackage

/* File: mask_reg_if.sv */
`timescale 1ns/100ps
// write path into one mask register and its stored value
interface mask_reg_if;
   logic wr; // one-cycle write strobe
   amp_int_pkg::reg_byte_t wdata; // value to store
   amp_int_pkg::reg_byte_t q; // stored mask
   modport owner (input wr, input wdata, output q);
   modport user (output wr, output wdata, input q);
endinterface

/* File: mask_reg.sv */
`timescale 1ns/100ps
// one 8-bit read/write mask register, all bits writable
module mask_reg #(
   parameter amp_int_pkg::reg_byte_t RESET_VAL = 8'h00
) (
   input wire logic ref_clk,
   input wire logic rst,
   mask_reg_if.owner bus
);
   amp_int_pkg::reg_byte_t mask_q; // stored value

   // reserved bits are stored like any other bit
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mask_q <= RESET_VAL;
      end else if (bus.wr) begin
         mask_q <= bus.wdata;
      end
   end

   assign bus.q = mask_q;
endmodule

/* File: src_sync.sv */
`timescale 1ns/100ps
// three-stage synchroniser per source with a two-stage agreement filter
module src_sync #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] live
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic s1_q; // first stage, read only by s2_q
         logic s2_q;
         logic s3_q;
         logic live_q; // filtered level
         // a change counts only once stages two and three agree
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               live_q <= 1'b0;
            end else begin
               s1_q <= raw[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  live_q <= s3_q;
               end
            end
         end
         assign live[i] = live_q;
      end
   endgenerate
endmodule

/* File: amp_interrupt_mask_bank.sv */
`timescale 1ns/100ps
`include "amp_int_cfg.svh"
// Functional notes
// RQ1: load diag done masked by bit5, resets 1
// RQ2: speaker field selects open/short/both masking
// RQ3: bit2 masks brownout power-down start, resets 1
// RQ4: bit1 masks brownout protection active, resets 1
// RQ5: bit0 battery brownout mask, resets 0
// RQ6: second reg bit7 masks modulator clock error
// RQ7: second reg bit6 masks boost clock error
// RQ8: second reg bit5 battery reset, resets 0
// RQ9: second reg bit4 masks pll lock event
// RQ10: second reg bit3 masks dc detect event
// RQ11: second reg bit2 masks boost overvoltage clamp
// RQ12: second reg bit1 masks charge pump good
// RQ13: second reg bit0 masks power-up event
// RQ14: third reg bit7 masks power-down event
// RQ15: third reg bit4 masks mic clock error
// RQ16: third reg bit3 masks serial clock error
// RQ17: live readback bit follows source condition
// RQ18: interrupt only from unmasked active sources
// RQ19: reserved bits writable, no interrupt effect
module amp_interrupt_mask_bank (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [5:0] src_load_brownout,
   input wire logic [7:0] src_clock_supply,
   input wire logic [2:0] src_power_clock,
   output logic int_req
);

   // carriers for the three mask registers
   mask_reg_if mask_lb_bus ();
   mask_reg_if mask_cs_bus ();
   mask_reg_if mask_pc_bus ();

   // mask values as seen by the gating logic
   amp_int_pkg::reg_byte_t mask_lb; // load and brownout masks
   amp_int_pkg::reg_byte_t mask_cs; // clock and supply masks
   amp_int_pkg::reg_byte_t mask_pc; // power and clock masks

   // filtered source levels
   logic [5:0] live_lb_raw; // load and brownout sources
   logic [7:0] live_cs_raw; // clock and supply sources
   logic [2:0] live_pc_raw; // down, mic, serial sources

   // live levels placed at the matching mask bit positions
   amp_int_pkg::reg_byte_t live_lb;
   amp_int_pkg::reg_byte_t live_cs;
   amp_int_pkg::reg_byte_t live_pc;

   // sources allowed through to the interrupt
   amp_int_pkg::reg_byte_t pend_lb;
   amp_int_pkg::reg_byte_t pend_cs;
   amp_int_pkg::reg_byte_t pend_pc;
   logic any_pend; // at least one unmasked active source

   // register decode
   amp_int_pkg::reg_sel_t sel; // which register the offset hits
   amp_int_pkg::reg_byte_t rd_mux; // value for the read answer
   amp_int_pkg::spk_mask_t spk_field; // speaker masking setting

   logic int_req_q; // registered interrupt request
   amp_int_pkg::reg_byte_t rdata_q; // registered read answer

   // source inputs come from analog monitors on other clocks
   src_sync #(.WIDTH(6)) u_sync_lb (
      .ref_clk (ref_clk),
      .rst (rst),
      .raw (src_load_brownout),
      .live (live_lb_raw)
   );

   src_sync #(.WIDTH(8)) u_sync_cs (
      .ref_clk (ref_clk),
      .rst (rst),
      .raw (src_clock_supply),
      .live (live_cs_raw)
   );

   src_sync #(.WIDTH(3)) u_sync_pc (
      .ref_clk (ref_clk),
      .rst (rst),
      .raw (src_power_clock),
      .live (live_pc_raw)
   );

   // live readback sits at the same bit as its mask
   assign live_lb = {2'b00, live_lb_raw}; // see RQ17
   assign live_cs = live_cs_raw; // see RQ17
   assign live_pc = {live_pc_raw[2], 2'b00, live_pc_raw[1], live_pc_raw[0], 3'b000}; // see RQ17

   // offset decode, one register per offset
   assign sel = (reg_addr == `MASK_LB_OFS) ? amp_int_pkg::SEL_MASK_LB :
                (reg_addr == `MASK_CS_OFS) ? amp_int_pkg::SEL_MASK_CS :
                (reg_addr == `MASK_PC_OFS) ? amp_int_pkg::SEL_MASK_PC :
                (reg_addr == `LIVE_LB_OFS) ? amp_int_pkg::SEL_LIVE_LB :
                (reg_addr == `LIVE_CS_OFS) ? amp_int_pkg::SEL_LIVE_CS :
                (reg_addr == `LIVE_PC_OFS) ? amp_int_pkg::SEL_LIVE_PC :
                amp_int_pkg::SEL_NONE;

   // write strobes; live registers ignore writes
   assign mask_lb_bus.wr = reg_wr && (sel == amp_int_pkg::SEL_MASK_LB);
   assign mask_cs_bus.wr = reg_wr && (sel == amp_int_pkg::SEL_MASK_CS);
   assign mask_pc_bus.wr = reg_wr && (sel == amp_int_pkg::SEL_MASK_PC);
   assign mask_lb_bus.wdata = reg_wdata;
   assign mask_cs_bus.wdata = reg_wdata;
   assign mask_pc_bus.wdata = reg_wdata;

   // reserved bits are stored with all others and read back
   mask_reg #(.RESET_VAL(`MASK_LB_RESET)) u_mask_lb ( // see RQ1 see RQ3 see RQ4 see RQ5 see RQ19
      .ref_clk (ref_clk),
      .rst (rst),
      .bus (mask_lb_bus.owner)
   );

   mask_reg #(.RESET_VAL(`MASK_CS_RESET)) u_mask_cs ( // see RQ6 see RQ7 see RQ8 see RQ9 see RQ10
      .ref_clk (ref_clk),
      .rst (rst),
      .bus (mask_cs_bus.owner)
   );

   mask_reg #(.RESET_VAL(`MASK_PC_RESET)) u_mask_pc ( // see RQ14 see RQ15 see RQ16 see RQ19
      .ref_clk (ref_clk),
      .rst (rst),
      .bus (mask_pc_bus.owner)
   );

   assign mask_lb = mask_lb_bus.q;
   assign mask_cs = mask_cs_bus.q;
   assign mask_pc = mask_pc_bus.q;

   // speaker field: low bit masks open load, high bit short load
   assign spk_field = amp_int_pkg::spk_mask_t'(mask_lb[`LB_SPK_MSB:`LB_SPK_LSB]); // see RQ2

   // gating: a set mask bit blocks its source; reserved bits never pass
   assign pend_lb = live_lb & ~mask_lb & `USED_LB; // see RQ1 see RQ2 see RQ3 see RQ4 see RQ5 see RQ19
   assign pend_cs = live_cs & ~mask_cs & `USED_CS; // see RQ6 see RQ7 see RQ8 see RQ9 see RQ10 see RQ11 see RQ12 see RQ13
   assign pend_pc = live_pc & ~mask_pc & `USED_PC; // see RQ14 see RQ15 see RQ16 see RQ19
   assign any_pend = (|pend_lb) || (|pend_cs) || (|pend_pc); // see RQ18

   // read selection
   assign rd_mux = (sel == amp_int_pkg::SEL_MASK_LB) ? mask_lb :
                   (sel == amp_int_pkg::SEL_MASK_CS) ? mask_cs :
                   (sel == amp_int_pkg::SEL_MASK_PC) ? mask_pc :
                   (sel == amp_int_pkg::SEL_LIVE_LB) ? live_lb :
                   (sel == amp_int_pkg::SEL_LIVE_CS) ? live_cs :
                   (sel == amp_int_pkg::SEL_LIVE_PC) ? live_pc :
                   `RDATA_NONE;

   // interrupt request is a level that follows the gated sources
   // one flop of delay keeps the pin glitch free during mask writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         int_req_q <= 1'b0;
      end else begin
         int_req_q <= any_pend; // see RQ18
      end
   end

   // read answer captured on the read strobe and held until the next
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= `RDATA_NONE;
      end else if (reg_rd) begin
         rdata_q <= rd_mux; // see RQ17
      end
   end

   assign int_req = int_req_q;
   assign reg_rdata = rdata_q;

   // ---- checks ----
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // previous-cycle reset flag so reset values can be checked
   logic rst_seen_q; // high in the first cycle after reset drops
   always_ff @(posedge ref_clk) begin
      rst_seen_q <= rst;
   end

   // reset values of the first register
   property p_lb_reset;
      rst_seen_q && !rst |-> mask_lb == `MASK_LB_RESET;
   endproperty
   a_lb_reset: assert property (p_lb_reset) else $error("load mask reset value wrong"); // see RQ1

   // reset values of the other two registers
   property p_cs_pc_reset;
      rst_seen_q && !rst |-> (mask_cs == `MASK_CS_RESET) && (mask_pc == `MASK_PC_RESET);
   endproperty
   a_cs_pc_reset: assert property (p_cs_pc_reset) else $error("clock or power mask reset wrong"); // see RQ8

   // battery brownout passes whenever its bit is clear, as it is after reset
   property p_batt_bo_open;
      live_lb[`LB_BATT_BO_BIT] && !mask_lb[`LB_BATT_BO_BIT] |-> pend_lb[`LB_BATT_BO_BIT];
   endproperty
   a_batt_bo_open: assert property (p_batt_bo_open) else $error("battery brownout blocked after reset"); // see RQ5

   // open load blocked for open and both settings only
   property p_spk_open;
      live_lb[`LB_SPK_LSB] |->
         pend_lb[`LB_SPK_LSB] == (spk_field == amp_int_pkg::SPK_MASK_NONE ||
                                  spk_field == amp_int_pkg::SPK_MASK_SHORT);
   endproperty
   a_spk_open: assert property (p_spk_open) else $error("open load gating wrong"); // see RQ2

   // short load blocked for short and both settings only
   property p_spk_short;
      live_lb[`LB_SPK_MSB] |->
         pend_lb[`LB_SPK_MSB] == (spk_field == amp_int_pkg::SPK_MASK_NONE ||
                                  spk_field == amp_int_pkg::SPK_MASK_OPEN);
   endproperty
   a_spk_short: assert property (p_spk_short) else $error("short load gating wrong"); // see RQ2

   // every named source of the second register obeys its mask bit
   property p_cs_gate;
      pend_cs == (live_cs & ~mask_cs);
   endproperty
   a_cs_gate: assert property (p_cs_gate) else $error("clock supply gating wrong"); // see RQ6

   // brownout bits pass exactly when unmasked
   property p_bo_gate;
      pend_lb[2:0] == (live_lb[2:0] & ~mask_lb[2:0]) && pend_lb[5] == (live_lb[5] && !mask_lb[5]);
   endproperty
   a_bo_gate: assert property (p_bo_gate) else $error("brownout or diag gating wrong"); // see RQ3

   // third register named bits gate, reserved bits never pass
   property p_pc_gate;
      pend_pc == {live_pc[7] & ~mask_pc[7], 2'b00, live_pc[4:3] & ~mask_pc[4:3], 3'b000};
   endproperty
   a_pc_gate: assert property (p_pc_gate) else $error("power clock gating wrong"); // see RQ14

   // reserved mask bits contribute nothing
   property p_reserved_quiet;
      pend_lb[7:6] == 2'b00 && pend_pc[6:5] == 2'b00 && pend_pc[2:0] == 3'b000;
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved bit reached interrupt"); // see RQ19

   // a write to the third mask register reaches it by the next edge
   property p_write_lands;
      reg_wr && reg_addr == `MASK_PC_OFS |=> mask_pc == $past(reg_wdata);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("mask write lost"); // see RQ19

   // an unmasked source raises the request one cycle later
   property p_irq_rise;
      any_pend |=> int_req;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt missing"); // see RQ18

   // request never stands without an unmasked source behind it
   property p_irq_cause;
      int_req |-> $past(any_pend);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without unmasked source"); // see RQ18

   // fully masked bank stays quiet for two cycles
   property p_all_masked;
      (mask_lb == 8'hff && mask_cs == 8'hff && mask_pc == 8'hff) [*2] |-> !int_req;
   endproperty
   a_all_masked: assert property (p_all_masked) else $error("masked source raised interrupt"); // see RQ18

   // live readback returns the filtered source levels
   property p_live_read;
      reg_rd && reg_addr == `LIVE_CS_OFS |=> reg_rdata == $past(live_cs);
   endproperty
   a_live_read: assert property (p_live_read) else $error("live readback wrong"); // see RQ17

   // a steady source shows in the live bit within four cycles
   property p_live_follow;
      $stable(src_clock_supply[0]) [*5] |-> live_cs[0] == src_clock_supply[0];
   endproperty
   a_live_follow: assert property (p_live_follow) else $error("live bit does not follow source"); // see RQ17

   // unmapped offsets read as zero
   property p_unmapped;
      reg_rd && sel == amp_int_pkg::SEL_NONE |=> reg_rdata == `RDATA_NONE;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   // speaker field starts with nothing masked
   property p_spk_reset;
      rst_seen_q && !rst |-> spk_field == amp_int_pkg::SPK_MASK_NONE;
   endproperty
   a_spk_reset: assert property (p_spk_reset) else $error("speaker field reset wrong"); // see RQ2

   // named clock and supply bits start masked, battery reset bit open
   property p_cs_named_reset;
      rst_seen_q && !rst |-> mask_cs[7] && mask_cs[6] && !mask_cs[5] && mask_cs[4] && mask_cs[3:0] == 4'hf;
   endproperty
   a_cs_named_reset: assert property (p_cs_named_reset) else $error("clock supply bit reset wrong"); // see RQ7 see RQ9

   // named power and clock bits start masked
   property p_pc_named_reset;
      rst_seen_q && !rst |-> mask_pc[`PC_DOWN_BIT] && mask_pc[`PC_MIC_BIT] && mask_pc[`PC_SERIAL_BIT];
   endproperty
   a_pc_named_reset: assert property (p_pc_named_reset) else $error("power clock bit reset wrong"); // see RQ15

   // request drops one cycle after the last unmasked source goes
   property p_irq_fall;
      !any_pend |=> !int_req;
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt stands without source"); // see RQ18

   // read and write in one cycle: the read answers the old value
   property p_read_old;
      reg_rd && reg_wr && sel == amp_int_pkg::SEL_MASK_CS |=> reg_rdata == $past(mask_cs);
   endproperty
   a_read_old: assert property (p_read_old) else $error("same cycle read did not see old value");

   // writes to live readback or unmapped offsets leave every mask alone
   property p_wr_ignored;
      reg_wr && sel != amp_int_pkg::SEL_MASK_LB && sel != amp_int_pkg::SEL_MASK_CS &&
         sel != amp_int_pkg::SEL_MASK_PC |=> $stable(mask_lb) && $stable(mask_cs) && $stable(mask_pc);
   endproperty
   a_wr_ignored: assert property (p_wr_ignored) else $error("ignored write changed a mask"); // see RQ17

   // masks keep their value, reserved bits included, until written
   property p_mask_hold;
      !reg_wr |=> $stable(mask_lb) && $stable(mask_cs) && $stable(mask_pc);
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write"); // see RQ19

   // read answer stands until the next read strobe
   property p_rdata_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read answer changed without strobe");

   // power-down source lands at bit 7 of the third live register
   property p_live_pc_place;
      $stable(src_power_clock[2]) [*5] |-> live_pc[`PC_DOWN_BIT] == src_power_clock[2];
   endproperty
   a_live_pc_place: assert property (p_live_pc_place) else $error("power-down live bit misplaced"); // see RQ14

   // short load source lands at the high bit of the speaker field
   property p_live_spk_place;
      $stable(src_load_brownout[4]) [*5] |-> live_lb[`LB_SPK_MSB] == src_load_brownout[4];
   endproperty
   a_live_spk_place: assert property (p_live_spk_place) else $error("short load live bit misplaced"); // see RQ2

   // main scenarios
   c_irq_raised: cover property (!int_req ##1 int_req);
   c_spk_both: cover property (spk_field == amp_int_pkg::SPK_MASK_BOTH && live_lb[4:3] == 2'b11);
   c_unmask_write: cover property (reg_wr && reg_addr == `MASK_CS_OFS && reg_wdata == 8'h00);
   c_masked_event: cover property (live_cs[4] && mask_cs[4] && !int_req);
   c_spk_open_only: cover property (spk_field == amp_int_pkg::SPK_MASK_OPEN && live_lb[4] && int_req);

endmodule

/* File: amp_interrupt_mask_bank_tb.sv */
`timescale 1ns/100ps
`include "amp_int_cfg.svh"
// self-checking bench for the mask bank, byte port driven 1 ns after each rising edge
module amp_interrupt_mask_bank_tb;
   logic ref_clk = 1'b0; // 25 MHz device clock
   logic rst = 1'b1; // synchronous, active high
   logic [7:0] reg_addr = 8'h00; // register offset
   logic reg_wr = 1'b0; // write strobe
   logic [7:0] reg_wdata = 8'h00; // write data
   logic reg_rd = 1'b0; // read strobe
   logic [7:0] reg_rdata; // read answer
   logic int_req; // interrupt request
   // source levels kept at the bit positions of their mask registers
   amp_int_pkg::reg_byte_t src_b [3] = '{default: 8'h00};
   wire logic [5:0] src_load_brownout; // load and brownout sources
   wire logic [7:0] src_clock_supply; // clock and supply sources
   wire logic [2:0] src_power_clock; // power and clock sources
   // per-register offsets, reset values and used bits
   localparam logic [7:0] MASK_OFS [3] = '{`MASK_LB_OFS, `MASK_CS_OFS, `MASK_PC_OFS};
   localparam logic [7:0] LIVE_OFS [3] = '{`LIVE_LB_OFS, `LIVE_CS_OFS, `LIVE_PC_OFS};
   localparam logic [7:0] RST_VAL [3] = '{`MASK_LB_RESET, `MASK_CS_RESET, `MASK_PC_RESET};
   localparam logic [7:0] USED [3] = '{`USED_LB, `USED_CS, `USED_PC};
   int failures = 0; // mismatches seen
   int n_checks = 0; // comparisons made
   amp_int_pkg::reg_byte_t rd_val; // value from the same-cycle read

   // third register packs its sources at bits 7, 4 and 3
   assign src_load_brownout = src_b[0][5:0];
   assign src_clock_supply = src_b[1];
   assign src_power_clock = {src_b[2][7], src_b[2][4], src_b[2][3]};

   amp_interrupt_mask_bank amp_interrupt_mask_bank_i (
      .ref_clk(ref_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .src_load_brownout(src_load_brownout),
      .src_clock_supply(src_clock_supply),
      .src_power_clock(src_power_clock),
      .int_req(int_req)
   );

   // free-running clock, 40 ns period
   always #20 ref_clk = ~ref_clk;

   // compare and count, report at once on mismatch
   task automatic chk(input amp_int_pkg::reg_byte_t seen, input amp_int_pkg::reg_byte_t exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one write strobe; the gap cycle after it keeps strobes from merging
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
   endtask

   // one read strobe, answer registered on the strobe edge
   task automatic rd(input logic [7:0] a, output amp_int_pkg::reg_byte_t d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   // read and compare
   task automatic rd_chk(input logic [7:0] a, input amp_int_pkg::reg_byte_t exp);
      amp_int_pkg::reg_byte_t d;
      rd(a, d);
      chk(d, exp);
   endtask

   // let a source change cross the filter and reach the request (8 edges, 5 needed)
   task automatic settle();
      repeat (8) @(posedge ref_clk);
      #1;
   endtask

   // request level compare
   task automatic int_chk(input logic e);
      chk({7'h00, int_req}, {7'h00, e});
   endtask

   // all masks and live bits at their reset values
   task automatic check_reset();
      for (int r = 0; r < 3; r++) begin
         rd_chk(MASK_OFS[r], RST_VAL[r]);
         rd_chk(LIVE_OFS[r], 8'h00);
      end
      int_chk(1'b0);
   endtask

   // verdict in one place
   task automatic complete_run();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // watchdog, well past the thousand or so cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      complete_run();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      check_reset();
      // unmapped offset answers zero, writes there and to live readback ignored
      wr(8'h30, 8'h5a);
      rd_chk(8'h30, `RDATA_NONE);
      wr(`LIVE_CS_OFS, 8'hff);
      rd_chk(`LIVE_CS_OFS, 8'h00);
      // every bit writable, reserved ones too
      for (int r = 0; r < 3; r++) begin
         wr(MASK_OFS[r], 8'h55);
         rd_chk(MASK_OFS[r], 8'h55);
         wr(MASK_OFS[r], 8'haa);
         rd_chk(MASK_OFS[r], 8'haa);
      end
      // write and read in one cycle: read returns the old value
      wr(`MASK_CS_OFS, 8'h12);
      @(posedge ref_clk);
      #1;
      reg_addr = `MASK_CS_OFS;
      reg_wdata = 8'h34;
      reg_wr = 1'b1;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      chk(reg_rdata, 8'h12);
      rd_chk(`MASK_CS_OFS, 8'h34);
      // each source alone: masked, then unmasked by its own bit, then masked again
      for (int r = 0; r < 3; r++) begin
         wr(MASK_OFS[r], 8'hff);
      end
      for (int r = 0; r < 3; r++) begin
         for (int k = 0; k < 8; k++) begin
            if (USED[r][k]) begin
               src_b[r][k] = 1'b1;
               settle();
               int_chk(1'b0);
               rd_chk(LIVE_OFS[r], 8'h01 << k);
               wr(MASK_OFS[r], ~(8'h01 << k));
               settle();
               int_chk(1'b1);
               wr(MASK_OFS[r], 8'hff);
               settle();
               int_chk(1'b0);
               src_b[r][k] = 1'b0;
               settle();
               rd_chk(LIVE_OFS[r], 8'h00);
            end
         end
      end
      // speaker field, all four codes against open then short load
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 2; s++) begin
            wr(`MASK_LB_OFS, {3'b111, c[1:0], 3'b111});
            src_b[0][3+s] = 1'b1;
            settle();
            int_chk(!c[s]);
            src_b[0][3+s] = 1'b0;
            settle();
         end
      end
      // reserved mask bits cleared, every source active, all real masks set
      wr(`MASK_LB_OFS, `USED_LB);
      wr(`MASK_PC_OFS, `USED_PC);
      for (int r = 0; r < 3; r++) begin
         src_b[r] = USED[r];
      end
      settle();
      int_chk(1'b0);
      rd_chk(`MASK_PC_OFS, `USED_PC);
      for (int r = 0; r < 3; r++) begin
         rd_chk(LIVE_OFS[r], USED[r]);
         wr(MASK_OFS[r], 8'h00);
      end
      settle();
      int_chk(1'b1);
      // sources off, then a second reset restores the defaults
      for (int r = 0; r < 3; r++) begin
         src_b[r] = 8'h00;
      end
      settle();
      int_chk(1'b0);
      @(posedge ref_clk);
      #1;
      rst = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      check_reset();
      complete_run();
   end
endmodule
